// ==== include/fewm_pkg.sv ====
/*
 * Shared constants and types for the flash erase/write and memory map
 * block. Assumes an 8-bit core with a byte SFR port and a byte data bus with 16-bit addresses.
 */
`default_nettype none
package fewm_pkg;
    // SFR offsets
    localparam logic [7:0] FEWM_SFR_TRIG = 8'h94;
    localparam logic [7:0] FEWM_SFR_CTRL = 8'hb2;
    localparam logic [7:0] FEWM_SFR_PAGE = 8'hb7;
    // Field positions in the write control register
    localparam int FEWM_GATE_BIT = 0;
    localparam int FEWM_ARM_BIT  = 1;
    localparam int FEWM_BUSY_BIT = 7;
    // Reset values
    localparam logic [1:0] FEWM_CTRL_RST = 2'h0;
    localparam logic [6:0] FEWM_PAGE_RST = 7'h00;
    // Erase patterns and erased byte
    localparam logic [7:0] FEWM_PAT_MASS = 8'haa;
    localparam logic [7:0] FEWM_PAT_PAGE = 8'h55;
    localparam logic [7:0] FEWM_ERASED   = 8'hff;
    // Flash geometry: 128 pages of 512 bytes
    localparam int FEWM_PAGE_SHIFT = 9;
    localparam logic [15:0] FEWM_PAGE_LAST = 16'h01ff;
    localparam logic [15:0] FEWM_MASS_LAST = 16'hffff;
    // Engine regions insert this many wait states
    localparam logic [2:0] FEWM_ENG_WAITS = 3'h5;
    // Data bus request carried from the core
    typedef struct packed {
        logic [15:0] addr;   // Byte address
        logic [7:0]  wdata;  // Store data
        logic        rd;     // Load, held until ack
        logic        wr;     // Store, held until ack
    } fewm_xreq_t;
    // Decoded data-space region
    typedef enum logic [2:0] {
        FEWM_RG_NONE  = 3'h0,
        FEWM_RG_MPU   = 3'h1,
        FEWM_RG_EDATA = 3'h2,
        FEWM_RG_CFG   = 3'h3,
        FEWM_RG_EPROG = 3'h4
    } fewm_region_t;
    // Bus sequencer states
    typedef enum logic [1:0] {
        FEWM_ST_IDLE = 2'b01,
        FEWM_ST_WAIT = 2'b10
    } fewm_state_t;
    // Address to region
    function automatic fewm_region_t fewm_decode(input logic [15:0] a);
        if (a[15:11] == 5'h00) return FEWM_RG_MPU;
        if (a[15:10] == 6'h04) return FEWM_RG_EDATA;
        if (a[15:8] == 8'h20)  return FEWM_RG_CFG;
        if (a[15:12] == 4'h3)  return FEWM_RG_EPROG;
        return FEWM_RG_NONE;
    endfunction
endpackage
`default_nettype wire

// ==== rtl/fewm_flash.sv ====
/*
 * 64KB flash array with code read port, byte program and erase walker.
 * Assumes the controller starts an erase only while busy is low.
 */
`timescale 1ns/1ns
`default_nettype none
module fewm_flash
    import fewm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [15:0] code_addr,
    input  wire logic        code_rd,
    input  wire logic        read_pulse_width_sel,
    output logic [7:0]       code_data,
    output logic             code_ack,
    output logic             read_strobe,
    input  wire logic        prog_en,
    input  wire logic [15:0] prog_addr,
    input  wire logic [7:0]  prog_data,
    input  wire logic        mass_go,
    input  wire logic        page_go,
    input  wire logic [6:0]  page_num,
    output logic             busy
);
    logic [7:0]  mem [65536];  // Non-volatile cells, never reset
    logic [15:0] ptr_q;        // Erase walk pointer
    logic [15:0] end_q;        // Last byte of the erase
    logic        take;         // Code read accepted

    // Reads stall while an erase walks the array
    assign take = code_rd && !busy && !code_ack;
    // Narrow pulse only on the accept cycle saves current
    assign read_strobe = read_pulse_width_sel ? take
                                              : (code_rd && !busy);

    // Code read, no wait states
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            code_ack  <= 1'b0;
            code_data <= 8'h00;
        end else begin
            code_ack <= take;
            if (take) begin
                code_data <= mem[code_addr];
            end
        end
    end

    // Erase walker, one byte a cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy  <= 1'b0;
            ptr_q <= 16'h0000;
            end_q <= 16'h0000;
        end else if (busy) begin
            ptr_q <= ptr_q + 16'h0001;
            busy  <= (ptr_q != end_q);
        end else if (mass_go) begin
            busy  <= 1'b1;
            ptr_q <= 16'h0000;
            end_q <= FEWM_MASS_LAST;
        end else if (page_go) begin
            busy  <= 1'b1;
            ptr_q <= {page_num, 9'h000};
            end_q <= {page_num, 9'h000} | FEWM_PAGE_LAST;
        end
    end

    // Cell writes: erase sets all ones, program only clears bits
    always_ff @(posedge ref_clk) begin
        if (busy) begin
            mem[ptr_q] <= FEWM_ERASED;
        end else if (prog_en) begin
            mem[prog_addr] <= mem[prog_addr] & prog_data;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    prog_clears_only_a: assert property (
        prog_en && !busy |=> mem[$past(prog_addr)] ==
            ($past(mem[prog_addr]) & $past(prog_data)))
        else $error("program set a cleared bit");
    code_ack_once_a: assert property (
        take |=> code_ack ##1 !code_ack)
        else $error("code read ack not one cycle");
endmodule
`default_nettype wire

// ==== rtl/fewm_top.sv ====
/*
 * Flash erase/write sequencer and data-space decoder for the 8-bit core.
 * Assumes the core drives the SFR port and data bus on ref_clk, holds a
 * data or code request until its ack, and keeps its own software duties.
 */
// How it works
// - 64KB flash, code reads without wait states
// - Decode engine and config RAM, engine waits five
// - 2KB processor RAM at bottom, no waits
// - One bit picks flash read pulse width
// - Mass erase: set arm, then write 0xaa
// - Mass erase needs emulation port enabled
// - Page erase: write page, then write 0x55
// - Only exact pattern and order erase
// - Write gate steers data stores into flash
// - Erased reads 0xff, programming clears bits
// - Flash program also writes matching RAM cell
// - Engine program RAM blocked while engine runs
// - Processor reads and writes engine data RAM
`timescale 1ns/1ns
`default_nettype none
module fewm_top
    import fewm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]       sfr_rdata,
    input  wire fewm_xreq_t  xreq,
    output logic [7:0]       xrdata,
    output logic             xack,
    input  wire logic [15:0] code_addr,
    input  wire logic        code_rd,
    output logic [7:0]       code_data,
    output logic             code_ack,
    output logic             read_strobe,
    input  wire logic        read_pulse_width_sel,
    input  wire logic        emulation_port,
    input  wire logic        engine_running
);
    // Data memories behind the decoder
    logic [7:0]   mpu_ram [2048];  // Battery-backed core RAM
    logic [7:0]   edata   [1024];  // Engine data RAM
    logic [7:0]   cfg_ram [256];   // Configuration RAM
    logic [7:0]   eprog   [4096];  // Engine program RAM
    // Control state
    logic         gate_q;          // Program write gate
    logic         arm_q;           // Mass erase arm
    logic [6:0]   page_q;          // Page to erase
    logic         page_set_q;      // Page written since last trigger
    logic         emul_meta_q;     // Pin synchroniser, first stage
    logic         emul_q;          // Pin synchroniser, second stage
    fewm_state_t  st_q;            // Bus sequencer state
    logic [2:0]   wait_q;          // Remaining wait states
    // Combinational terms
    fewm_region_t rg;              // Region of current request
    logic         eng;             // Region inserts waits
    logic         take;            // Request accepted
    logic         perform;         // Access happens this cycle
    logic         trig_wr;         // Any write to erase trigger
    logic         mass_go;         // Start mass erase
    logic         page_go;         // Start page erase
    logic         fl_busy;         // Erase walking
    logic         eprog_ok;        // Engine program RAM reachable
    logic         prog_en;         // Gated store goes to flash

    assign rg   = fewm_decode(xreq.addr);
    assign eng  = (rg == FEWM_RG_EDATA) || (rg == FEWM_RG_EPROG);
    // Gated stores wait for the erase walker to finish
    assign take = (st_q == FEWM_ST_IDLE) && !xack &&
                  (xreq.rd || xreq.wr) &&
                  !(xreq.wr && gate_q && fl_busy);
    assign perform = (take && !eng) ||
                     ((st_q == FEWM_ST_WAIT) && (wait_q == 3'h1));
    assign eprog_ok = !engine_running;
    assign prog_en  = perform && xreq.wr && gate_q;

    // Emulation enable comes from a pin
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            emul_meta_q <= 1'b0;
            emul_q      <= 1'b0;
        end else begin
            emul_meta_q <= emulation_port;
            emul_q      <= emul_meta_q;
        end
    end

    // Erase start decode; anything else is dropped silently
    assign trig_wr = sfr_wr && (sfr_addr == FEWM_SFR_TRIG);
    assign mass_go = trig_wr && (sfr_wdata == FEWM_PAT_MASS) &&
                     arm_q && emul_q && !fl_busy;
    assign page_go = trig_wr && (sfr_wdata == FEWM_PAT_PAGE) &&
                     page_set_q && !fl_busy;

    // Write control register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            {arm_q, gate_q} <= FEWM_CTRL_RST;
        end else if (sfr_wr && (sfr_addr == FEWM_SFR_CTRL)) begin
            gate_q <= sfr_wdata[FEWM_GATE_BIT];
            arm_q  <= sfr_wdata[FEWM_ARM_BIT];
        end else if (trig_wr) begin
            // Every trigger write disarms, so one arm is one try
            arm_q <= 1'b0;
        end
    end

    // Page select and its ordering flag
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            page_q     <= FEWM_PAGE_RST;
            page_set_q <= 1'b0;
        end else if (sfr_wr && (sfr_addr == FEWM_SFR_PAGE)) begin
            page_q     <= sfr_wdata[7:1];
            page_set_q <= 1'b1;
        end else if (trig_wr) begin
            page_set_q <= 1'b0;
        end
    end

    // SFR read-back; unknown offsets read zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                FEWM_SFR_CTRL: sfr_rdata <= {fl_busy, 5'h00, arm_q, gate_q};
                FEWM_SFR_PAGE: sfr_rdata <= {page_q, 1'b0};
                default:       sfr_rdata <= 8'h00;
            endcase
        end
    end

    // Bus sequencer: zero-wait answers next cycle, engine after waits
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q   <= FEWM_ST_IDLE;
            wait_q <= 3'h0;
        end else begin
            unique case (st_q)
                FEWM_ST_IDLE: begin
                    if (take && eng) begin
                        st_q   <= FEWM_ST_WAIT;
                        wait_q <= FEWM_ENG_WAITS;
                    end
                end
                FEWM_ST_WAIT: begin
                    wait_q <= wait_q - 3'h1;
                    if (wait_q == 3'h1) begin
                        st_q <= FEWM_ST_IDLE;
                    end
                end
                default: st_q <= FEWM_ST_IDLE;
            endcase
        end
    end

    // Answer and load data; blocked program RAM reads zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            xack   <= 1'b0;
            xrdata <= 8'h00;
        end else begin
            xack <= perform;
            if (perform && xreq.rd) begin
                unique case (rg)
                    FEWM_RG_MPU:   xrdata <= mpu_ram[xreq.addr[10:0]];
                    FEWM_RG_EDATA: xrdata <= edata[xreq.addr[9:0]];
                    FEWM_RG_CFG:   xrdata <= cfg_ram[xreq.addr[7:0]];
                    FEWM_RG_EPROG: xrdata <= eprog_ok ?
                                   eprog[xreq.addr[11:0]] : 8'h00;
                    default:       xrdata <= 8'h00;
                endcase
            end
        end
    end

    // RAM stores; a gated store also lands here
    always_ff @(posedge ref_clk) begin
        if (perform && xreq.wr) begin
            unique case (rg)
                FEWM_RG_MPU: begin
                    mpu_ram[xreq.addr[10:0]] <= xreq.wdata;
                end
                FEWM_RG_EDATA: begin
                    edata[xreq.addr[9:0]] <= xreq.wdata;
                end
                FEWM_RG_CFG: begin
                    cfg_ram[xreq.addr[7:0]] <= xreq.wdata;
                end
                FEWM_RG_EPROG: begin
                    if (eprog_ok) begin
                        eprog[xreq.addr[11:0]] <= xreq.wdata;
                    end
                end
                default: ;
            endcase
        end
    end

    // Flash array with erase walker
    fewm_flash u_flash (
        .ref_clk              (ref_clk),
        .rst                  (rst),
        .code_addr            (code_addr),
        .code_rd              (code_rd),
        .read_pulse_width_sel (read_pulse_width_sel),
        .code_data            (code_data),
        .code_ack             (code_ack),
        .read_strobe          (read_strobe),
        .prog_en              (prog_en),
        .prog_addr            (xreq.addr),
        .prog_data            (xreq.wdata),
        .mass_go              (mass_go),
        .page_go              (page_go),
        .page_num             (page_q),
        .busy                 (fl_busy)
    );

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    engine_wait_a: assert property (
        take && eng |=> !xack [*5] ##1 xack)
        else $error("engine access not five waits");
    zero_wait_a: assert property (
        take && !eng |=> xack ##1 !xack)
        else $error("zero wait access late");
    erase_cause_a: assert property (
        !fl_busy ##1 fl_busy |-> $past(trig_wr) &&
            ($past(sfr_wdata) == FEWM_PAT_MASS ||
             $past(sfr_wdata) == FEWM_PAT_PAGE))
        else $error("erase started without trigger");
    mass_needs_emul_a: assert property (
        trig_wr && (sfr_wdata == FEWM_PAT_MASS) && !emul_q && !fl_busy
        |=> !fl_busy)
        else $error("mass erase without emulation port");
    trig_disarm_a: assert property (
        trig_wr |=> !arm_q && !page_set_q)
        else $error("trigger write left arm set");
    page_order_a: assert property (
        trig_wr && (sfr_wdata == FEWM_PAT_PAGE) && !page_set_q
        && !fl_busy |=> !fl_busy)
        else $error("page erase without page select");
    eprog_block_a: assert property (
        perform && xreq.rd && (rg == FEWM_RG_EPROG) && engine_running
        |=> xack && (xrdata == 8'h00))
        else $error("engine program RAM read while running");
    gate_prog_a: assert property (
        take && !eng && xreq.wr && gate_q |-> prog_en)
        else $error("gated store missed flash");

    mass_erase_c: cover property (mass_go ##1 fl_busy);
    page_erase_c: cover property (page_go ##1 fl_busy);
    engine_read_c: cover property (take && eng && xreq.rd ##6 xack);
endmodule
`default_nettype wire

// ==== bench/fewm_core_model.sv ====
/*
 * Core model: drives the SFR port, data bus and code port of the block.
 * Assumes the bench calls its tasks one at a time on ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module fewm_core_model
    import fewm_pkg::*;
(
    input  wire logic        ref_clk,
    output logic [7:0]       sfr_addr,
    output logic             sfr_wr,
    output logic             sfr_rd,
    output logic [7:0]       sfr_wdata,
    input  wire logic [7:0]  sfr_rdata,
    output fewm_xreq_t       xreq,
    input  wire logic [7:0]  xrdata,
    input  wire logic        xack,
    output logic [15:0]      code_addr,
    output logic             code_rd,
    input  wire logic [7:0]  code_data,
    input  wire logic        code_ack,
    input  wire logic        read_strobe
);
    logic global_interrupt_control;  // Core interrupt mask

    // Idle bus at time zero
    initial begin
        {sfr_addr, sfr_wr, sfr_rd, sfr_wdata} = '0;
        xreq = '0;
        {code_addr, code_rd} = '0;
        global_interrupt_control = 1'b0;
    end

    // One-cycle write strobe; address inverted once released
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'b1};
        @(posedge ref_clk);
        {sfr_addr, sfr_wdata, sfr_wr} <= {~a, ~d, 1'b0};
    endtask

    // Read data is registered, so take it one edge after the strobe
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        {sfr_addr, sfr_rd} <= {a, 1'b1};
        @(posedge ref_clk);
        {sfr_addr, sfr_rd} <= {~a, 1'b0};
        @(posedge ref_clk);
        d = sfr_rdata;
    endtask

    // Lat counts edges to the answer; zero means none came
    task automatic xfer(input logic w, input logic [15:0] a,
                        input logic [7:0] wd, output logic [7:0] q,
                        output int lat);
        lat = 0;
        @(posedge ref_clk);
        xreq <= '{addr: a, wdata: wd, rd: !w, wr: w};
        for (int n = 1; n <= 100; n++) begin
            @(posedge ref_clk);
            if (xack === 1'b1) begin
                lat = n;
                q = xrdata;
                xreq <= '{addr: ~a, wdata: ~wd, rd: 1'b0, wr: 1'b0};
                break;
            end
        end
    endtask

    // Counts read strobe cycles while the fetch is held
    task automatic fetch(input logic [15:0] a, output logic [7:0] q,
                         output int lat, output int stb);
        lat = 0;
        stb = 0;
        @(posedge ref_clk);
        {code_addr, code_rd} <= {a, 1'b1};
        for (int n = 1; n <= 100; n++) begin
            @(posedge ref_clk);
            stb += int'(read_strobe === 1'b1);
            if (code_ack === 1'b1) begin
                lat = n;
                q = code_data;
                {code_addr, code_rd} <= {~a, 1'b0};
                break;
            end
        end
    endtask

    // Gate stores only with interrupts masked, then clear the gate
    task automatic set_gate(input logic on);
        if (on) global_interrupt_control = 1'b1;
        sfr_write(FEWM_SFR_CTRL, {7'h00, on});
        if (!on) global_interrupt_control = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== bench/flash_erase_write_memory_map_tb.sv ====
/*
 * Bench for the flash erase/write block: sequences of core model calls
 * with expected values. Assumes fewm_top and fewm_core_model.
 */
`timescale 1ns/1ns
`default_nettype none
module flash_erase_write_memory_map_tb
    import fewm_pkg::*;
;
    logic        ref_clk = 1'b0;               // 250 MHz
    logic        rst = 1'b1;                   // Sync, active high
    logic        read_pulse_width_sel = 1'b1;  // Narrow pulse first
    logic        emulation_port = 1'b0;        // Off at start
    logic        engine_running = 1'b0;        // Engine stopped
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xrdata, code_data;
    logic        sfr_wr, sfr_rd, xack, code_rd, code_ack, read_strobe;
    logic [15:0] code_addr;                    // Fetch address
    fewm_xreq_t  xreq;                         // Data bus request
    int          err_count = 0;                // Mismatches
    int          num_checks = 0;               // Comparisons

    always #2 ref_clk = ~ref_clk;

    fewm_top dut (.ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .xreq(xreq), .xrdata(xrdata), .xack(xack),
        .code_addr(code_addr), .code_rd(code_rd), .code_data(code_data),
        .code_ack(code_ack), .read_strobe(read_strobe),
        .read_pulse_width_sel(read_pulse_width_sel),
        .emulation_port(emulation_port), .engine_running(engine_running));

    fewm_core_model core (.ref_clk(ref_clk), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .xreq(xreq), .xrdata(xrdata), .xack(xack),
        .code_addr(code_addr), .code_rd(code_rd), .code_data(code_data),
        .code_ack(code_ack), .read_strobe(read_strobe));

    // Single place that ends the run
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        core.sfr_read(a, d);
        check("sfr read", exp, d);
    endtask

    // Engine regions answer five cycles later than the rest
    task automatic xchk(input logic w, input logic [15:0] a,
                        input logic [7:0] wd, input logic [7:0] exp);
        logic [7:0] q;
        int         lat;
        int         want;
        want = (a inside {[16'h1000:16'h13ff], [16'h3000:16'h3fff]}) ?
               2 + FEWM_ENG_WAITS : 2;
        core.xfer(w, a, wd, q, lat);
        check("xack latency", 8'(want), 8'(lat));
        if (!w) check("load data", exp, q);
    endtask

    task automatic fchk(input logic [15:0] a, input logic [7:0] exp,
                        input logic [7:0] nstb);
        logic [7:0] q;
        int         lat;
        int         stb;
        core.fetch(a, q, lat, stb);
        check("fetch latency", 8'h02, 8'(lat));
        check("fetch data", exp, q);
        check("read strobes", nstb, 8'(stb));
    endtask

    // Poll the busy flag; a run that never ends is cut off here
    task automatic wait_idle();
        logic [7:0] d;
        for (int i = 0; i < 25000; i++) begin
            core.sfr_read(FEWM_SFR_CTRL, d);
            if (d[FEWM_BUSY_BIT] === 1'b0) return;
        end
        err_count++;
        $display("wrong value erase busy expected 0 seen 1");
        stop_test();
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        rchk(FEWM_SFR_CTRL, 8'h00);
        rchk(FEWM_SFR_PAGE, 8'h00);
        rchk(FEWM_SFR_TRIG, 8'h00);
        core.sfr_write(FEWM_SFR_PAGE, 8'h0b);
        rchk(FEWM_SFR_PAGE, 8'h0a);
        // Armed mass erase with the emulation port off is refused
        core.sfr_write(FEWM_SFR_CTRL, 8'h02);
        rchk(FEWM_SFR_CTRL, 8'h02);
        core.sfr_write(FEWM_SFR_TRIG, FEWM_PAT_MASS);
        rchk(FEWM_SFR_CTRL, 8'h00);
        emulation_port <= 1'b1;
        repeat (3) @(posedge ref_clk);
        core.sfr_write(FEWM_SFR_CTRL, 8'h02);
        core.sfr_write(FEWM_SFR_TRIG, 8'h5a);
        rchk(FEWM_SFR_CTRL, 8'h00);
        core.sfr_write(FEWM_SFR_TRIG, FEWM_PAT_MASS);
        rchk(FEWM_SFR_CTRL, 8'h00);
        core.sfr_write(FEWM_SFR_TRIG, FEWM_PAT_PAGE);
        rchk(FEWM_SFR_CTRL, 8'h00);
        core.sfr_write(FEWM_SFR_CTRL, 8'h02);
        core.sfr_write(FEWM_SFR_TRIG, FEWM_PAT_MASS);
        rchk(FEWM_SFR_CTRL, 8'h80);
        wait_idle();
        fchk(16'h0000, FEWM_ERASED, 8'h01);
        fchk(16'hffff, FEWM_ERASED, 8'h01);
        // RAM map without the gate leaves flash alone
        xchk(1'b1, 16'h07ff, 8'h3c, 8'h00);
        xchk(1'b0, 16'h07ff, 8'h00, 8'h3c);
        xchk(1'b1, 16'h0800, 8'h11, 8'h00);
        xchk(1'b0, 16'h0800, 8'h00, 8'h00);
        fchk(16'h07ff, FEWM_ERASED, 8'h01);
        xchk(1'b1, 16'h13ff, 8'h77, 8'h00);
        xchk(1'b0, 16'h13ff, 8'h00, 8'h77);
        xchk(1'b1, 16'h20ff, 8'h44, 8'h00);
        xchk(1'b0, 16'h20ff, 8'h00, 8'h44);
        xchk(1'b0, 16'h1400, 8'h00, 8'h00);
        // Engine code loaded before the engine starts
        xchk(1'b1, 16'h3000, 8'h66, 8'h00);
        engine_running <= 1'b1;
        xchk(1'b0, 16'h3000, 8'h00, 8'h00);
        xchk(1'b1, 16'h3000, 8'h99, 8'h00);
        engine_running <= 1'b0;
        xchk(1'b0, 16'h3000, 8'h00, 8'h66);
        // Gated stores program flash and also land in core and config RAM
        core.set_gate(1'b1);
        xchk(1'b1, 16'h0010, 8'hf0, 8'h00);
        xchk(1'b1, 16'h2010, 8'h5a, 8'h00);
        xchk(1'b1, 16'h0200, 8'h00, 8'h00);
        xchk(1'b1, 16'h0010, 8'h3c, 8'h00);
        core.set_gate(1'b0);
        fchk(16'h0010, 8'h30, 8'h01);
        fchk(16'h2010, 8'h5a, 8'h01);
        xchk(1'b0, 16'h2010, 8'h00, 8'h5a);
        xchk(1'b0, 16'h0010, 8'h00, 8'h3c);
        // Page image read back from core RAM before the erase
        xchk(1'b0, 16'h0200, 8'h00, 8'h00);
        core.sfr_write(FEWM_SFR_PAGE, 8'h02);
        core.sfr_write(FEWM_SFR_TRIG, FEWM_PAT_PAGE);
        rchk(FEWM_SFR_CTRL, 8'h80);
        wait_idle();
        fchk(16'h0200, FEWM_ERASED, 8'h01);
        read_pulse_width_sel <= 1'b0;
        fchk(16'h0010, 8'h30, 8'h02);
        stop_test();
    end
endmodule
`default_nettype wire
